/* File: rtl/flow_ctrl_consts.vh */
`ifndef FLOW_CTRL_CONSTS_VH
`define FLOW_CTRL_CONSTS_VH

// register indexes on the plain register port
`define ADDR_FEATURE      4'h0
`define ADDR_MODEM        4'h1
`define ADDR_INT_ENABLE   4'h2
`define ADDR_INT_IDENT    4'h3
`define ADDR_THRESHOLD    4'h4
`define ADDR_RESUME_1     4'h5
`define ADDR_RESUME_2     4'h6
`define ADDR_PAUSE_1      4'h7
`define ADDR_PAUSE_2      4'h8
`define ADDR_LINE_CTRL    4'h9
`define ADDR_BAUD_DIV     4'hA
`define ADDR_STATUS       4'hB

// feature_ctrl_reg fields
`define FC_AUTO_CTS       7
`define FC_AUTO_RTS       6
`define FC_SPECIAL        5
`define FC_TX_HI          3
`define FC_TX_LO          2
`define FC_RX_HI          1
`define FC_RX_LO          0

// modem_ctrl_reg fields
`define MC_RESUME_ANY     5
`define MC_RTS            1

// int_enable_reg field
`define IE_PAUSE          5

// int_ident_reg read values
`define IDENT_PAUSE       8'h10
`define IDENT_NONE        8'h01

// two-bit flow selections
`define SEL_NONE          2'h0
`define SEL_PAIR1         2'h2
`define SEL_PAIR2         2'h1
`define SEL_BOTH          2'h3

// reset values
`define RST_ZERO          8'h00
`define RST_BAUD_DIV      8'h01
`define RST_LINE_CTRL     8'h03

// one threshold step counts four fifo entries (shift of 2)
`define THR_SHIFT         2

// last oversampling tick of a serial bit, and mid point of a bit
`define TICKS_LAST        4'hF
`define TICKS_MID         4'h7

`endif

/* File: rtl/uart_tx_shifter.v */
`timescale 1ns/10ps
`include "flow_ctrl_consts.vh"
module uart_tx_shifter (
  // clock and reset
  input  wire       i_clock,
  input  wire       i_nrst,
  // 16x bit-rate enable
  input  wire       i_tick,
  // character request
  input  wire       i_start,
  input  wire [7:0] i_data,
  input  wire [1:0] i_wlen,
  // serial side and status
  output reg        o_tx,
  output wire       o_busy,
  output wire       o_stop_mid
);

  localparam S_IDLE  = 2'd0;
  localparam S_START = 2'd1;
  localparam S_DATA  = 2'd2;
  localparam S_STOP  = 2'd3;

  reg [1:0] state_reg;
  reg [3:0] sub_reg;
  reg [2:0] bit_reg;
  reg [7:0] shift_reg;

  wire [2:0] last_bit = {1'b1, i_wlen} ;
  wire       bit_end  = i_tick && (sub_reg == `TICKS_LAST);

  assign o_busy     = (state_reg != S_IDLE);
  assign o_stop_mid = (state_reg == S_STOP) && i_tick &&
                      (sub_reg == `TICKS_MID);

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= S_IDLE;
      sub_reg   <= 4'h0;
      bit_reg   <= 3'h0;
      shift_reg <= 8'h00;
      o_tx      <= 1'b1;
    end else begin
      if (i_tick)
        sub_reg <= sub_reg + 4'h1;
      case (state_reg)
        S_IDLE: begin
          o_tx <= 1'b1;
          if (i_start) begin
            shift_reg <= i_data;
            state_reg <= S_START;
            sub_reg   <= 4'h0;
            o_tx      <= 1'b0;
          end
        end
        S_START: begin
          if (bit_end) begin
            state_reg <= S_DATA;
            bit_reg   <= 3'h0;
            o_tx      <= shift_reg[0];
          end
        end
        S_DATA: begin
          if (bit_end) begin
            // only the low word-length bits go out
            if (bit_reg == last_bit) begin
              state_reg <= S_STOP;
              o_tx      <= 1'b1;
            end else begin
              bit_reg   <= bit_reg + 3'h1;
              shift_reg <= {1'b0, shift_reg[7:1]};
              o_tx      <= shift_reg[1];
            end
          end
        end
        S_STOP: begin
          if (bit_end)
            state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

endmodule // uart_tx_shifter

/* File: rtl/uart_flow_ctrl.v */
`timescale 1ns/10ps
`include "flow_ctrl_consts.vh"
module uart_flow_ctrl (
  // clock and reset
  input  wire       i_clock,
  input  wire       i_nrst,
  // register port
  input  wire [3:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // received characters from the deserialiser
  input  wire       i_rx_valid,
  input  wire [7:0] i_rx_data,
  input  wire       i_rx_err,
  // receive fifo
  input  wire [6:0] i_rxf_level,
  output reg        o_rxf_wr,
  output reg  [7:0] o_rxf_data,
  // transmit fifo
  input  wire       i_txf_empty,
  input  wire [7:0] i_txf_data,
  output wire       o_txf_rd,
  // modem pins and interrupt
  input  wire       i_cts_n,
  output reg        o_rts_n,
  output wire       o_tx,
  output wire       o_int
);

  localparam T_IDLE = 1'b0;
  localparam T_SEND = 1'b1;

  // threshold nibble to fifo entries
  function [6:0] thr;
    input [3:0] n;
    begin
      thr = {1'b0, n, 2'b00};
    end
  endfunction

  reg [7:0] feature_ctrl_reg;
  reg [7:0] modem_ctrl_reg;
  reg [7:0] int_enable_reg;
  reg [7:0] flow_threshold_reg;
  reg [7:0] resume_char_1;
  reg [7:0] resume_char_2;
  reg [7:0] pause_char_1;
  reg [7:0] pause_char_2;
  reg [7:0] line_ctrl_reg;
  reg [7:0] baud_div_reg;

  reg       flag_reg;
  reg       flag_src_special_reg;
  reg       halted_reg;
  reg       held_v_reg;
  reg       held_resume_reg;
  reg [7:0] held_d_reg;
  reg       reissue_v_reg;
  reg [7:0] reissue_d_reg;
  reg       reissue_e_reg;
  reg       pause_sent_reg;
  reg [1:0] sent_sel_reg;
  reg       tok_state_reg;
  reg       tok_resume_reg;
  reg [1:0] tok_sel_reg;
  reg       tok_idx_reg;
  reg       cts_meta_reg;
  reg       cts_sync_reg;
  reg       cts_block_reg;
  reg       start_gap_reg;
  reg [7:0] div_cnt_reg;
  reg       tick_reg;

  wire [1:0] rsel = feature_ctrl_reg[`FC_RX_HI:`FC_RX_LO];
  wire [1:0] tsel = feature_ctrl_reg[`FC_TX_HI:`FC_TX_LO];
  wire       ident_rd = i_rd && (i_addr == `ADDR_INT_IDENT);

  // register writes
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      feature_ctrl_reg   <= `RST_ZERO;
      modem_ctrl_reg     <= `RST_ZERO;
      int_enable_reg     <= `RST_ZERO;
      flow_threshold_reg <= `RST_ZERO;
      resume_char_1      <= `RST_ZERO;
      resume_char_2      <= `RST_ZERO;
      pause_char_1       <= `RST_ZERO;
      pause_char_2       <= `RST_ZERO;
      line_ctrl_reg      <= `RST_LINE_CTRL;
      baud_div_reg       <= `RST_BAUD_DIV;
    end else if (i_wr) begin
      case (i_addr)
        `ADDR_FEATURE:    feature_ctrl_reg   <= i_wdata;
        `ADDR_MODEM:      modem_ctrl_reg     <= i_wdata;
        `ADDR_INT_ENABLE: int_enable_reg     <= i_wdata;
        `ADDR_THRESHOLD:  flow_threshold_reg <= i_wdata;
        `ADDR_RESUME_1:   resume_char_1      <= i_wdata;
        `ADDR_RESUME_2:   resume_char_2      <= i_wdata;
        `ADDR_PAUSE_1:    pause_char_1       <= i_wdata;
        `ADDR_PAUSE_2:    pause_char_2       <= i_wdata;
        `ADDR_LINE_CTRL:  line_ctrl_reg      <= i_wdata;
        `ADDR_BAUD_DIV:   baud_div_reg       <= i_wdata;
        default: ;
      endcase
    end
  end

  // register reads, data one cycle after the strobe
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `ADDR_FEATURE:    o_rdata <= feature_ctrl_reg;
        `ADDR_MODEM:      o_rdata <= modem_ctrl_reg;
        `ADDR_INT_ENABLE: o_rdata <= int_enable_reg;
        `ADDR_INT_IDENT:  o_rdata <= flag_reg ? `IDENT_PAUSE
                                              : `IDENT_NONE;
        `ADDR_THRESHOLD:  o_rdata <= flow_threshold_reg;
        `ADDR_RESUME_1:   o_rdata <= resume_char_1;
        `ADDR_RESUME_2:   o_rdata <= resume_char_2;
        `ADDR_PAUSE_1:    o_rdata <= pause_char_1;
        `ADDR_PAUSE_2:    o_rdata <= pause_char_2;
        `ADDR_LINE_CTRL:  o_rdata <= line_ctrl_reg;
        `ADDR_BAUD_DIV:   o_rdata <= baud_div_reg;
        `ADDR_STATUS:     o_rdata <= {4'h0, pause_sent_reg, tok_state_reg,
                                      cts_block_reg, halted_reg};
        default:          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // receive side: a deferred char replays one cycle after a broken pair;
  // char strobes are a character time apart so the slot never collides
  wire       in_v = reissue_v_reg | i_rx_valid;
  wire [7:0] in_d = reissue_v_reg ? reissue_d_reg : i_rx_data;
  wire       in_e = reissue_v_reg ? reissue_e_reg : i_rx_err;

  wire p1 = !in_e && (in_d == pause_char_1);
  wire p2 = !in_e && (in_d == pause_char_2);
  wire r1 = !in_e && (in_d == resume_char_1);
  wire r2 = !in_e && (in_d == resume_char_2);

  wire mode_any = (rsel == `SEL_BOTH) &&
                  (tsel == `SEL_PAIR1 || tsel == `SEL_PAIR2);
  wire mode_seq = (rsel == `SEL_BOTH) && !mode_any;

  wire single_p = (rsel == `SEL_PAIR1 && p1) ||
                  (rsel == `SEL_PAIR2 && p2) ||
                  (mode_any && (p1 || p2));
  wire single_r = (rsel == `SEL_PAIR1 && r1) ||
                  (rsel == `SEL_PAIR2 && r2) ||
                  (mode_any && (r1 || r2));
  wire resume_any = halted_reg && modem_ctrl_reg[`MC_RESUME_ANY];

  reg       act_pause;
  reg       act_resume;
  reg       special;
  reg       hold_set;
  reg       hold_clr;
  reg       reissue;
  reg       wr;
  reg [7:0] wr_d;

  always @* begin
    act_pause  = 1'b0;
    act_resume = 1'b0;
    special    = 1'b0;
    hold_set   = 1'b0;
    hold_clr   = 1'b0;
    reissue    = 1'b0;
    wr         = 1'b0;
    wr_d       = in_d;
    if (in_v) begin
      if (held_v_reg) begin
        hold_clr = 1'b1;
        if (held_resume_reg ? r2 : p2) begin
          act_pause  = !held_resume_reg;
          act_resume = held_resume_reg;
        end else begin
          wr      = 1'b1;
          wr_d    = held_d_reg;
          reissue = 1'b1;
        end
      end else if (single_p) begin
        act_pause = 1'b1;
      end else if (resume_any && !(mode_seq && p1)) begin
        act_resume = 1'b1;
        // a first resume char acts alone here, so it is stored
        wr = !single_r;
      end else if (single_r) begin
        act_resume = 1'b1;
      end else if (mode_seq && (p1 || r1)) begin
        hold_set = 1'b1;
      end else begin
        wr = 1'b1;
      end
      if (wr && !reissue && feature_ctrl_reg[`FC_SPECIAL] &&
          !in_e && (in_d == pause_char_2))
        special = 1'b1;
    end
  end

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rxf_wr        <= 1'b0;
      o_rxf_data      <= 8'h00;
      held_v_reg      <= 1'b0;
      held_resume_reg <= 1'b0;
      held_d_reg      <= 8'h00;
      reissue_v_reg   <= 1'b0;
      reissue_d_reg   <= 8'h00;
      reissue_e_reg   <= 1'b0;
      halted_reg      <= 1'b0;
    end else begin
      o_rxf_wr      <= wr;
      if (wr)
        o_rxf_data  <= wr_d;
      reissue_v_reg <= reissue;
      if (reissue) begin
        reissue_d_reg <= in_d;
        reissue_e_reg <= in_e;
      end
      if (hold_set) begin
        held_v_reg      <= 1'b1;
        held_resume_reg <= r1;
        held_d_reg      <= in_d;
      end else if (hold_clr) begin
        held_v_reg      <= 1'b0;
      end
      if (act_pause)
        halted_reg <= 1'b1;
      else if (act_resume)
        halted_reg <= 1'b0;
    end
  end

  // pause flag: a new event beats a clear in the same cycle
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_reg             <= 1'b0;
      flag_src_special_reg <= 1'b0;
    end else if (act_pause) begin
      flag_reg             <= 1'b1;
      flag_src_special_reg <= 1'b0;
    end else if (special) begin
      flag_reg             <= 1'b1;
      flag_src_special_reg <= 1'b1;
    end else if (act_resume && !flag_src_special_reg) begin
      flag_reg             <= 1'b0;
    end else if (ident_rd && flag_src_special_reg) begin
      flag_reg             <= 1'b0;
      flag_src_special_reg <= 1'b0;
    end
  end

  assign o_int = flag_reg && int_enable_reg[`IE_PAUSE];

  // 16x bit-rate enable, divisor 0 behaves as 1
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      div_cnt_reg <= 8'h00;
      tick_reg    <= 1'b0;
    end else if (div_cnt_reg == 8'h00) begin
      div_cnt_reg <= (baud_div_reg == 8'h00) ? 8'h00
                                             : baud_div_reg - 8'h01;
      tick_reg    <= 1'b1;
    end else begin
      div_cnt_reg <= div_cnt_reg - 8'h01;
      tick_reg    <= 1'b0;
    end
  end

  // transmit side
  wire       tx_busy;
  wire       stop_mid;
  wire       auto_cts = feature_ctrl_reg[`FC_AUTO_CTS];
  wire       can_start = !tx_busy && !start_gap_reg;
  wire       above = i_rxf_level > thr(flow_threshold_reg[3:0]);
  wire       at_resume = i_rxf_level <= thr(flow_threshold_reg[7:4]);
  wire       need_resume = pause_sent_reg &&
                           (at_resume || tsel != sent_sel_reg);
  wire       need_pause = !pause_sent_reg && tsel != `SEL_NONE &&
                          above;
  wire       tok_go = can_start &&
                      (tok_state_reg == T_SEND || need_resume || need_pause);
  wire       go_resume = (tok_state_reg == T_SEND) ? tok_resume_reg
                                                   : need_resume;
  wire [1:0] go_sel = (tok_state_reg == T_SEND) ? tok_sel_reg :
                      need_resume ? sent_sel_reg : tsel;
  wire       go_second = (go_sel == `SEL_PAIR2) ||
                         (tok_state_reg == T_SEND && tok_idx_reg);
  wire [7:0] tok_char = go_resume ? (go_second ? resume_char_2
                                               : resume_char_1)
                                  : (go_second ? pause_char_2
                                               : pause_char_1);
  wire       tok_more = (go_sel == `SEL_BOTH) &&
                        !(tok_state_reg == T_SEND && tok_idx_reg);

  assign o_txf_rd = can_start && !tok_go && !i_txf_empty && !halted_reg &&
                    !(auto_cts && cts_block_reg);

  wire       tx_start = tok_go || o_txf_rd;
  wire [7:0] tx_data = tok_go ? tok_char : i_txf_data;

  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      tok_state_reg  <= T_IDLE;
      tok_resume_reg <= 1'b0;
      tok_sel_reg    <= `SEL_NONE;
      tok_idx_reg    <= 1'b0;
      pause_sent_reg <= 1'b0;
      sent_sel_reg   <= `SEL_NONE;
      start_gap_reg  <= 1'b0;
    end else begin
      start_gap_reg <= tx_start;
      if (tok_go) begin
        case (tok_state_reg)
          T_IDLE: begin
            tok_resume_reg <= go_resume;
            tok_sel_reg    <= go_sel;
          end
          T_SEND: ;
          default: ;
        endcase
        if (tok_more) begin
          tok_state_reg <= T_SEND;
          tok_idx_reg   <= 1'b1;
        end else begin
          tok_state_reg <= T_IDLE;
          tok_idx_reg   <= 1'b0;
          if (go_resume) begin
            pause_sent_reg <= 1'b0;
          end else begin
            pause_sent_reg <= 1'b1;
            sent_sel_reg   <= go_sel;
          end
        end
      end
    end
  end

  // cts pin synchroniser; mid last stop bit decides the next character
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cts_meta_reg  <= 1'b1;
      cts_sync_reg  <= 1'b1;
      cts_block_reg <= 1'b0;
    end else begin
      cts_meta_reg <= i_cts_n;
      cts_sync_reg <= cts_meta_reg;
      if (!auto_cts)
        cts_block_reg <= 1'b0;
      else if (!tx_busy || stop_mid)
        cts_block_reg <= cts_sync_reg;
    end
  end

  // auto rts follows fifo level with hysteresis
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rts_n <= 1'b1;
    end else if (!feature_ctrl_reg[`FC_AUTO_RTS]) begin
      o_rts_n <= !modem_ctrl_reg[`MC_RTS];
    end else if (i_rxf_level >= thr(flow_threshold_reg[3:0])) begin
      o_rts_n <= 1'b1;
    end else if (at_resume) begin
      o_rts_n <= 1'b0;
    end
  end

  uart_tx_shifter u_shifter (
    .i_clock    (i_clock),
    .i_nrst     (i_nrst),
    .i_tick     (tick_reg),
    .i_start    (tx_start),
    .i_data     (tx_data),
    .i_wlen     (line_ctrl_reg[1:0]),
    .o_tx       (o_tx),
    .o_busy     (tx_busy),
    .o_stop_mid (stop_mid)
  );

endmodule // uart_flow_ctrl

/* File: sim/uart_flow_ctrl_assertions.sv */
`timescale 1ns/10ps
`include "flow_ctrl_consts.vh"
module flow_ctrl_checker (
  input wire       i_clock,
  input wire       i_nrst,
  input wire [3:0] i_addr,
  input wire [7:0] i_wdata,
  input wire       i_wr,
  input wire       i_rd,
  input wire [7:0] o_rdata,
  input wire       i_rx_valid,
  input wire [7:0] i_rx_data,
  input wire       i_rx_err,
  input wire [6:0] i_rxf_level,
  input wire       o_rxf_wr,
  input wire [7:0] o_rxf_data,
  input wire       i_txf_empty,
  input wire [7:0] i_txf_data,
  input wire       o_txf_rd,
  input wire       i_cts_n,
  input wire       o_rts_n,
  input wire       o_tx,
  input wire       o_int
);
  // chars come at least 3 cycles apart, so this holds for two cycles
  logic [7:0] last_rx;
  always @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst)
      last_rx <= 8'h00;
    else if (i_rx_valid)
      last_rx <= i_rx_data;
  end

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  sequence s_rd_ident;
    i_rd && i_addr == `ADDR_INT_IDENT;
  endsequence
  sequence s_fifo_start;
    o_txf_rd ##1 !o_tx;
  endsequence
  sequence s_err_char;
    i_rx_valid && i_rx_err;
  endsequence

  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside read slot");
  a_ident_code: assert property (s_rd_ident |=>
    o_rdata == `IDENT_PAUSE || o_rdata == `IDENT_NONE)
    else $error("ident code not pause or none");
  a_ident_int: assert property (s_rd_ident ##0 o_int |=>
    o_rdata == `IDENT_PAUSE)
    else $error("interrupt high but ident shows none");
  a_unmapped_zero: assert property (i_rd && i_addr > 4'hB |=>
    o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_rd_nonempty: assert property (o_txf_rd |-> !i_txf_empty)
    else $error("transmit fifo read while empty");
  a_fifo_start: assert property (o_txf_rd |-> s_fifo_start)
    else $error("no start bit after fifo read");
  a_err_stored: assert property (s_err_char |->
    ##[1:2] (o_rxf_wr && o_rxf_data == last_rx))
    else $error("errored char not stored");
  a_rxf_cause: assert property (o_rxf_wr |->
    $past(i_rx_valid) || $past(i_rx_valid, 2))
    else $error("rx fifo write without a char");
  a_int_cause: assert property ($rose(o_int) |->
    $past(i_rx_valid) || $past(i_rx_valid, 2) || $past(i_wr))
    else $error("interrupt rose without cause");
endmodule // flow_ctrl_checker

/* File: sim/remote_uart_model.sv */
`timescale 1ns/10ps
module remote_uart_model (
  input  wire       i_clock,
  input  wire       i_serial,
  input  wire [1:0] i_wlen,
  output reg        o_valid,
  output reg  [7:0] o_char
);
  integer k;
  // assumes divisor 1: 16 clocks a bit, samples at bit middle
  initial begin
    o_valid = 1'b0;
    o_char  = 8'h00;
    forever begin
      @(negedge i_serial);
      repeat (8) @(posedge i_clock);
      if (!i_serial) begin
        o_char = 8'h00;
        for (k = 0; k < 5 + i_wlen; k = k + 1) begin
          repeat (16) @(posedge i_clock);
          o_char[k] = i_serial;
        end
        repeat (16) @(posedge i_clock);
        // a missing stop bit drops the char
        o_valid <= i_serial;
        @(posedge i_clock);
        o_valid <= 1'b0;
      end
    end
  end
endmodule // remote_uart_model

/* File: sim/tb_uart_flow_ctrl.sv */
`timescale 1ns/10ps
`include "flow_ctrl_consts.vh"
module tb_uart_flow_ctrl;
  logic       i_clock, i_nrst, i_wr, i_rd, i_rx_valid, i_rx_err;
  logic       o_rxf_wr, i_txf_empty, o_txf_rd, i_cts_n;
  logic       o_rts_n, o_tx, o_int, ser_valid;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, i_rx_data, o_rxf_data, i_txf_data;
  logic [7:0] ser_char, rdv, fc;
  logic [6:0] i_rxf_level;
  logic [1:0] wlen;
  logic [7:0] txq[$];
  logic [7:0] serq[$];
  logic [7:0] rxfq[$];
  integer     err_total, n_compared, i;

  uart_flow_ctrl uart_flow_ctrl_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
    .i_rx_err(i_rx_err), .i_rxf_level(i_rxf_level),
    .o_rxf_wr(o_rxf_wr), .o_rxf_data(o_rxf_data),
    .i_txf_empty(i_txf_empty), .i_txf_data(i_txf_data),
    .o_txf_rd(o_txf_rd), .i_cts_n(i_cts_n), .o_rts_n(o_rts_n),
    .o_tx(o_tx), .o_int(o_int));
  remote_uart_model remote_uart_model_inst (
    .i_clock(i_clock), .i_serial(o_tx), .i_wlen(wlen),
    .o_valid(ser_valid), .o_char(ser_char));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  // fall-through transmit fifo and capture of both outgoing streams
  always @(posedge i_clock) begin
    if (o_txf_rd && txq.size() > 0)
      void'(txq.pop_front());
    i_txf_empty <= (txq.size() == 0);
    i_txf_data  <= (txq.size() > 0) ? txq[0] : 8'h00;
    if (ser_valid)
      serq.push_back(ser_char);
    if (o_rxf_wr)
      rxfq.push_back(o_rxf_data);
  end

  task check(input string what, input logic [7:0] seen, exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask

  task finish_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    begin
      i_addr  <= a;
      i_wdata <= d;
      i_wr    <= 1'b1;
      @(posedge i_clock);
      i_wr <= 1'b0;
      @(posedge i_clock);
    end
  endtask

  task rd(input logic [3:0] a);
    begin
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      @(posedge i_clock);
      rdv = o_rdata;
    end
  endtask

  task rx_char(input logic [7:0] d, input logic err);
    begin
      i_rx_data  <= d;
      i_rx_err   <= err;
      i_rx_valid <= 1'b1;
      @(posedge i_clock);
      i_rx_valid <= 1'b0;
      repeat (4) @(posedge i_clock);
    end
  endtask

  task expect_ser(input logic [7:0] exp);
    integer n;
    begin
      n = 0;
      while (serq.size() == 0 && n < 600) begin
        @(posedge i_clock);
        n = n + 1;
      end
      check("serial char", serq.size() ? serq.pop_front() : 8'hXX, exp);
    end
  endtask

  task expect_quiet;
    begin
      repeat (400) @(posedge i_clock);
      check("serial idle", 8'(serq.size()), 8'h00);
    end
  endtask

  task check_rxf(input logic [7:0] exp);
    check("rx fifo", rxfq.size() ? rxfq.pop_front() : 8'hXX, exp);
  endtask

  task wait_start;
    integer n;
    begin
      n = 0;
      while (o_txf_rd !== 1'b1 && n < 600) begin
        @(posedge i_clock);
        n = n + 1;
      end
      check("tx start", o_txf_rd, 1'b1);
    end
  endtask

  task test_regs;
    begin
      rd(`ADDR_LINE_CTRL);
      check("line reset", rdv, `RST_LINE_CTRL);
      rd(`ADDR_BAUD_DIV);
      check("baud reset", rdv, `RST_BAUD_DIV);
      rd(`ADDR_INT_IDENT);
      check("ident reset", rdv, `IDENT_NONE);
      wr(4'hC, 8'h5A);
      rd(4'hC);
      check("unmapped", rdv, `RST_ZERO);
      wr(`ADDR_RESUME_1, 8'hA5);
      rd(`ADDR_RESUME_1);
      check("resume char", rdv, 8'hA5);
      $display("test_regs done");
    end
  endtask

  task test_cts;
    begin
      wr(`ADDR_FEATURE, 8'h80);
      txq.push_back(8'h41);
      txq.push_back(8'h42);
      expect_ser(8'h41);
      expect_ser(8'h42);
      txq.push_back(8'h43);
      txq.push_back(8'h44);
      wait_start;
      repeat (20) @(posedge i_clock);
      i_cts_n <= 1'b1;
      expect_ser(8'h43);
      expect_quiet;
      i_cts_n <= 1'b0;
      expect_ser(8'h44);
      $display("test_cts done");
    end
  endtask

  task test_pause;
    begin
      wr(`ADDR_PAUSE_1, 8'h13);
      wr(`ADDR_RESUME_1, 8'h11);
      wr(`ADDR_INT_ENABLE, 8'h20);
      wr(`ADDR_FEATURE, 8'h02);
      txq.push_back(8'h31);
      txq.push_back(8'h32);
      wait_start;
      rx_char(8'h13, 1'b0);
      check("pause int", o_int, 1'b1);
      rd(`ADDR_INT_IDENT);
      check("ident pause", rdv, `IDENT_PAUSE);
      check("token kept", 8'(rxfq.size()), 8'h00);
      expect_ser(8'h31);
      expect_quiet;
      rx_char(8'h11, 1'b0);
      check("resume int", o_int, 1'b0);
      expect_ser(8'h32);
      rx_char(8'h13, 1'b1);
      check_rxf(8'h13);
      check("errored int", o_int, 1'b0);
      $display("test_pause done");
    end
  endtask

  task test_special;
    begin
      wr(`ADDR_FEATURE, 8'h20);
      wr(`ADDR_PAUSE_2, 8'h55);
      rx_char(8'h55, 1'b0);
      check_rxf(8'h55);
      check("special int", o_int, 1'b1);
      txq.push_back(8'h33);
      expect_ser(8'h33);
      rd(`ADDR_INT_IDENT);
      check("ident special", rdv, `IDENT_PAUSE);
      rd(`ADDR_INT_IDENT);
      check("ident cleared", rdv, `IDENT_NONE);
      check("special off", o_int, 1'b0);
      $display("test_special done");
    end
  endtask

  task test_pairs;
    begin
      wr(`ADDR_FEATURE, 8'h03);
      wr(`ADDR_PAUSE_2, 8'h93);
      wr(`ADDR_RESUME_2, 8'h91);
      rx_char(8'h13, 1'b0);
      rx_char(8'h41, 1'b0);
      check_rxf(8'h13);
      check_rxf(8'h41);
      check("half pair", o_int, 1'b0);
      rx_char(8'h13, 1'b0);
      rx_char(8'h93, 1'b0);
      check("pair pause", o_int, 1'b1);
      rx_char(8'h11, 1'b0);
      rx_char(8'h91, 1'b0);
      check("pair resume", o_int, 1'b0);
      wr(`ADDR_FEATURE, 8'h0B);
      rx_char(8'h93, 1'b0);
      check("either pause", o_int, 1'b1);
      rx_char(8'h11, 1'b0);
      check("either resume", o_int, 1'b0);
      check("pairs kept", 8'(rxfq.size()), 8'h00);
      $display("test_pairs done");
    end
  endtask

  task test_tokens;
    begin
      wr(`ADDR_LINE_CTRL, 8'h02);
      wlen <= 2'd2;
      wr(`ADDR_PAUSE_1, 8'h93);
      wr(`ADDR_RESUME_1, 8'h91);
      wr(`ADDR_PAUSE_2, 8'h8F);
      wr(`ADDR_RESUME_2, 8'h8D);
      wr(`ADDR_THRESHOLD, 8'h13);
      for (i = 0; i < 3; i = i + 1) begin
        fc = (i == 0) ? 8'h08 : (i == 1) ? 8'h04 : 8'h0C;
        wr(`ADDR_FEATURE, fc);
        i_rxf_level <= 7'd13;
        if (fc[3]) expect_ser(8'h13);
        if (fc[2]) expect_ser(8'h0F);
        i_rxf_level <= 7'd4;
        if (fc[3]) expect_ser(8'h11);
        if (fc[2]) expect_ser(8'h0D);
      end
      wr(`ADDR_FEATURE, 8'h08);
      i_rxf_level <= 7'd13;
      expect_ser(8'h13);
      wr(`ADDR_FEATURE, 8'h04);
      expect_ser(8'h11);
      expect_ser(8'h0F);
      wr(`ADDR_FEATURE, 8'h00);
      expect_ser(8'h0D);
      expect_quiet;
      i_rxf_level <= 7'd0;
      wr(`ADDR_FEATURE, 8'h02);
      wr(`ADDR_MODEM, 8'h20);
      rx_char(8'h93, 1'b0);
      txq.push_back(8'h35);
      expect_quiet;
      rx_char(8'h41, 1'b0);
      expect_ser(8'h35);
      check_rxf(8'h41);
      wr(`ADDR_FEATURE, 8'h40);
      @(posedge i_clock);
      check("rts low", o_rts_n, 1'b0);
      i_rxf_level <= 7'd12;
      repeat (2) @(posedge i_clock);
      check("rts high", o_rts_n, 1'b1);
      $display("test_tokens done");
    end
  endtask

  initial begin
    i_nrst      = 1'b0;
    i_addr      = 4'h0;
    i_wdata     = 8'h00;
    i_wr        = 1'b0;
    i_rd        = 1'b0;
    i_rx_valid  = 1'b0;
    i_rx_data   = 8'h00;
    i_rx_err    = 1'b0;
    i_rxf_level = 7'h00;
    i_txf_empty = 1'b1;
    i_txf_data  = 8'h00;
    i_cts_n     = 1'b0;
    wlen        = 2'd3;
    err_total   = 0;
    n_compared  = 0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    @(posedge i_clock);
    test_regs;
    test_cts;
    test_pause;
    test_special;
    test_pairs;
    test_tokens;
    finish_test;
  end

  // whole run needs about 5000 cycles
  initial begin
    repeat (60000) @(posedge i_clock);
    err_total = err_total + 1;
    $display("watchdog expired");
    finish_test;
  end
endmodule // tb_uart_flow_ctrl

bind uart_flow_ctrl flow_ctrl_checker flow_ctrl_checker_inst (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data),
  .i_rx_err(i_rx_err), .i_rxf_level(i_rxf_level),
  .o_rxf_wr(o_rxf_wr), .o_rxf_data(o_rxf_data),
  .i_txf_empty(i_txf_empty), .i_txf_data(i_txf_data),
  .o_txf_rd(o_txf_rd), .i_cts_n(i_cts_n), .o_rts_n(o_rts_n),
  .o_tx(o_tx), .o_int(o_int));
